// >>> shared/eeprom_slave_pkg.sv
// Purpose: shared constants and types of the two-wire eeprom slave front end
// Assumes: core clock of 50 MHz
// Notes: glitch counts are derived from the suppression widths

package eeprom_slave_pkg;

  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int CORE_CLK_MHZ = 50;
  localparam int CORE_CLK_PERIOD_NS = 1000 / CORE_CLK_MHZ;
  localparam int GLITCH_STD_NS = 100;
  localparam int GLITCH_FAST_NS = 50;
  localparam int GLITCH_STD_CYCLES =
    (GLITCH_STD_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
  localparam int GLITCH_FAST_CYCLES =
    (GLITCH_FAST_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
  localparam int GLITCH_CNT_W = 3;
  localparam int INTERNAL_WRITE_TIME_US = 10000;
  localparam int INTERNAL_WRITE_CYCLES = INTERNAL_WRITE_TIME_US * CORE_CLK_MHZ;

  // ----------------------------------------
  // slave address byte layout
  // ----------------------------------------
  localparam int BYTE_W = 8;
  localparam int TYPE_W = 4;
  localparam int SELECT_W = 3;
  localparam int TYPE_MSB = 7;
  localparam int TYPE_LSB = 4;
  localparam int SELECT_MSB = 3;
  localparam int SELECT_LSB = 1;
  localparam int RW_POS = 0;
  localparam logic RW_READ = 1'b1;
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [3:0] ACK_CLOCK = 4'h9;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic LINE_IDLE = 1'b1;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SLAVE = 3'b001,
    ST_ARRAY = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100,
    ST_IGNORE = 3'b101
  } bus_state_t;

endpackage

// >>> shared/pin_filter_if.sv
// Purpose: carrier between a pin conditioner and its user
// Assumes: all signals in the core clock domain except raw
// Notes: raw is an asynchronous pin level

`timescale 1ns/1ns

interface pin_filter_if;
  logic raw;
  logic fast;
  logic level;
  modport filt (input raw, input fast, output level);
  modport user (output raw, output fast, input level);
endinterface

// >>> rtl/pin_filter.sv
// Purpose: two flop synchroniser and glitch filter for one bus pin
// Assumes: fast is already synchronous to clk
// Notes: level follows the pin only after it holds steady long enough

`timescale 1ns/1ns

module pin_filter
  import eeprom_slave_pkg::*;
#(
  parameter int CNT_W = GLITCH_CNT_W
) (
  input wire logic clk,
  input wire logic rst_n,
  pin_filter_if.filt pin
);

  logic meta;
  logic sync;
  logic level;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] need;

  // ----------------------------------------
  // synchroniser
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= LINE_IDLE;
      sync <= LINE_IDLE;
    end else begin
      meta <= pin.raw;
      sync <= meta;
    end
  end

  // ----------------------------------------
  // glitch filter
  // ----------------------------------------
  assign need = pin.fast ? CNT_W'(GLITCH_FAST_CYCLES) : CNT_W'(GLITCH_STD_CYCLES);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level <= LINE_IDLE;
      cnt <= '0;
    end else if (sync == level) begin
      cnt <= '0;
    end else if (cnt == need - CNT_W'(1)) begin
      level <= sync; // (RQ16)
      cnt <= '0;
    end else begin
      cnt <= cnt + CNT_W'(1);
    end
  end

  assign pin.level = level;

endmodule

// >>> rtl/eeprom_bus_slave.sv
// Purpose: two-wire bus slave front end of a small serial eeprom
// Assumes: master drives the clock line; memory array lives outside
// Notes: framing runs on the core clock, data bits land on the bus clock
//
// Overview of operation
// (RQ1) stop after a write starts internal write
// (RQ2) busy during write: line released, no ack
// (RQ3) master opens each transaction with start
// (RQ4) receiver acks each byte unless ending
// (RQ5) device acks writes, master acks reads
// (RQ6) master ends each transaction with stop
// (RQ7) master sends slave address then array address
// (RQ8) slave byte: type, select, direction bit
// (RQ9) respond only when type field matches
// (RQ10) select field must equal strap pins
// (RQ11) single page block, select bits choose device
// (RQ12) direction bit one reads, zero writes
// (RQ13) transmitter releases line after eight bits
// (RQ14) receiver drives line low on ninth clock
// (RQ15) second byte is the array address
// (RQ16) suppress input pulses narrower than filter width
// (RQ17) start is data fall, clock high
// (RQ18) stop is data rise, clock high
// (RQ19) data changes only while clock low
// (RQ20) unmatched address: stay released until start
// (RQ21) sample bits on rising clock, msb first

`timescale 1ns/1ns

module eeprom_bus_slave
  import eeprom_slave_pkg::*;
#(
  parameter logic [3:0] DEVICE_TYPE = 4'h6, // arbitrary value
  parameter int WRITE_CYCLES = INTERNAL_WRITE_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic LINK_SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic SELECT_STRAP_BIT0,
  input wire logic SELECT_STRAP_BIT1,
  input wire logic SELECT_STRAP_BIT2,
  input wire logic MODE_FAST,
  input wire logic [7:0] TX_DATA,
  output logic TX_LOAD,
  output logic [7:0] ARRAY_ADDR,
  output logic ADDR_VALID,
  output logic [7:0] RX_DATA,
  output logic RX_VALID,
  output logic WRITE_BUSY,
  output logic START_PROGRAM
);

  localparam int TIMER_W = $clog2(WRITE_CYCLES + 1);

  pin_filter_if scl_pin ();
  pin_filter_if sda_pin ();

  logic [2:0] strap_meta;
  logic [2:0] strap;
  logic fast_meta;
  logic fast;
  logic [7:0] link_shift;
  logic [7:0] word_meta;
  logic [7:0] rx_word;
  logic scl;
  logic sda;
  logic scl_q;
  logic sda_q;
  logic ev_start;
  logic ev_stop;
  logic ev_rise;
  logic ev_fall;
  logic byte_end;
  logic ack_end;
  logic addr_match;
  logic m_nack;
  logic wrote;
  logic busy;
  logic [TIMER_W-1:0] timer;
  logic [3:0] bit_cnt;
  logic [7:0] tx_shift;
  logic sda_oe;
  bus_state_t state;

  // ----------------------------------------
  // link domain shifter
  // ----------------------------------------
  always_ff @(posedge LINK_SCL or negedge NRST) begin
    if (!NRST) begin
      link_shift <= BYTE_RESET;
    end else begin
      link_shift <= {link_shift[6:0], SDA_IN}; // (RQ21)
    end
  end

  // ----------------------------------------
  // crossings into the core domain
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      strap_meta <= '0;
      strap <= '0;
      fast_meta <= 1'b0;
      fast <= 1'b0;
      word_meta <= BYTE_RESET;
      rx_word <= BYTE_RESET;
    end else begin
      strap_meta <= {SELECT_STRAP_BIT2, SELECT_STRAP_BIT1, SELECT_STRAP_BIT0};
      strap <= strap_meta;
      fast_meta <= MODE_FAST;
      fast <= fast_meta;
      word_meta <= link_shift;
      rx_word <= word_meta;
    end
  end

  assign scl_pin.raw = LINK_SCL;
  assign scl_pin.fast = fast;
  assign sda_pin.raw = SDA_IN;
  assign sda_pin.fast = fast;

  pin_filter u_scl_filter (
    .clk (CORE_CLK),
    .rst_n (NRST),
    .pin (scl_pin)
  );

  pin_filter u_sda_filter (
    .clk (CORE_CLK),
    .rst_n (NRST),
    .pin (sda_pin)
  );

  assign scl = scl_pin.level;
  assign sda = sda_pin.level;

  // ----------------------------------------
  // bus event detection
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      scl_q <= LINE_IDLE;
      sda_q <= LINE_IDLE;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  assign ev_start = !busy && sda_q && !sda && scl && scl_q; // (RQ17)
  assign ev_stop = !busy && !sda_q && sda && scl && scl_q; // (RQ18)
  assign ev_rise = !busy && scl && !scl_q;
  assign ev_fall = !busy && !scl && scl_q; // (RQ19)
  assign byte_end = ev_fall && (bit_cnt == DATA_BITS);
  assign ack_end = ev_fall && (bit_cnt == ACK_CLOCK);
  assign addr_match = (rx_word[TYPE_MSB:TYPE_LSB] == DEVICE_TYPE) // (RQ8) (RQ9)
    && (rx_word[SELECT_MSB:SELECT_LSB] == strap); // (RQ10) (RQ11)

  // ----------------------------------------
  // protocol state
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      state <= ST_IDLE;
    end else if (ev_start) begin
      state <= ST_SLAVE;
    end else if (ev_stop) begin
      state <= ST_IDLE;
    end else if (byte_end) begin
      case (state)
        ST_SLAVE: begin
          if (!addr_match) begin
            state <= ST_IGNORE; // (RQ20)
          end else if (rx_word[RW_POS] == RW_READ) begin
            state <= ST_RDATA; // (RQ12)
          end else begin
            state <= ST_ARRAY;
          end
        end
        ST_ARRAY: begin
          state <= ST_WDATA; // (RQ15)
        end
        default: begin
          state <= state;
        end
      endcase
    end else if (ack_end && state == ST_RDATA && m_nack) begin
      state <= ST_IGNORE; // (RQ4)
    end
  end

  // ----------------------------------------
  // bit counter, nine clocks per byte
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      bit_cnt <= '0;
    end else if (ev_start || ev_stop || ack_end) begin
      bit_cnt <= '0;
    end else if (ev_rise && bit_cnt != ACK_CLOCK) begin
      bit_cnt <= bit_cnt + 4'h1;
    end
  end

  // ----------------------------------------
  // data line drive
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      sda_oe <= 1'b0;
      tx_shift <= BYTE_RESET;
    end else if (busy || ev_start || ev_stop) begin
      sda_oe <= 1'b0; // (RQ2)
    end else if (byte_end) begin
      case (state)
        ST_SLAVE: begin
          sda_oe <= addr_match; // (RQ14) (RQ20)
        end
        ST_ARRAY, ST_WDATA: begin
          sda_oe <= 1'b1; // (RQ5) (RQ14)
        end
        default: begin
          sda_oe <= 1'b0; // (RQ13)
        end
      endcase
    end else if (ack_end) begin
      if (state == ST_RDATA && !m_nack) begin
        tx_shift <= TX_DATA;
        sda_oe <= !TX_DATA[7];
      end else begin
        sda_oe <= 1'b0; // (RQ14)
      end
    end else if (ev_fall && state == ST_RDATA && bit_cnt != 4'h0) begin
      tx_shift <= {tx_shift[6:0], 1'b0};
      sda_oe <= !tx_shift[6];
    end
  end

  assign SDA_OE = sda_oe;
  assign SDA_OUT = 1'b0;

  // ----------------------------------------
  // master acknowledge on reads
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      m_nack <= 1'b0;
    end else if (byte_end && state == ST_SLAVE) begin
      m_nack <= 1'b0;
    end else if (ev_rise && bit_cnt == DATA_BITS && state == ST_RDATA) begin
      m_nack <= sda; // (RQ5)
    end
  end

  // ----------------------------------------
  // user side results
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      ARRAY_ADDR <= BYTE_RESET;
      ADDR_VALID <= 1'b0;
      RX_DATA <= BYTE_RESET;
      RX_VALID <= 1'b0;
      TX_LOAD <= 1'b0;
    end else begin
      ADDR_VALID <= byte_end && state == ST_ARRAY;
      RX_VALID <= byte_end && state == ST_WDATA;
      TX_LOAD <= ack_end && state == ST_RDATA && !m_nack && !busy;
      if (byte_end && state == ST_ARRAY) begin
        ARRAY_ADDR <= rx_word; // (RQ15)
      end
      if (byte_end && state == ST_WDATA) begin
        RX_DATA <= rx_word;
      end
    end
  end

  // ----------------------------------------
  // write sequence and internal write timer
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      wrote <= 1'b0;
    end else if (ev_start || ev_stop) begin
      wrote <= 1'b0;
    end else if (byte_end && state == ST_WDATA) begin
      wrote <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      busy <= 1'b0;
      timer <= '0;
      START_PROGRAM <= 1'b0;
    end else begin
      START_PROGRAM <= ev_stop && wrote; // (RQ1)
      if (ev_stop && wrote) begin
        busy <= 1'b1; // (RQ1)
        timer <= TIMER_W'(WRITE_CYCLES - 1);
      end else if (busy && timer == '0) begin
        busy <= 1'b0;
      end else if (busy) begin
        timer <= timer - TIMER_W'(1);
      end
    end
  end

  assign WRITE_BUSY = busy;

endmodule

// >>> tb/eeprom_bus_slave_sva.sv
// Purpose: port checker of eeprom_bus_slave
// Assumes: core clock domain only
// Notes: bound after the module
`timescale 1ns/1ns
module eeprom_bus_slave_sva #(
  parameter int WRITE_CYCLES = 2000
) (
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic LINK_SCL,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_LOAD,
  input wire logic ADDR_VALID,
  input wire logic RX_VALID,
  input wire logic WRITE_BUSY,
  input wire logic START_PROGRAM
);
  // ----
  // busy length and port relations
  // ----
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  int busy_cnt;
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) busy_cnt <= 0;
    else busy_cnt <= WRITE_BUSY ? busy_cnt + 1 : 0;
  end
  a_busy_released: assert property (WRITE_BUSY |-> !SDA_OE) else $error("drive when busy");
  a_pull_low_only: assert property (SDA_OE |-> !SDA_OUT) else $error("drives high");
  a_prog_then_busy: assert property (START_PROGRAM |-> ##[0:1] WRITE_BUSY)
    else $error("no busy after program");
  a_busy_has_cause: assert property (
    $rose(WRITE_BUSY) |-> START_PROGRAM || $past(START_PROGRAM))
    else $error("busy without program");
  a_busy_length: assert property ($fell(WRITE_BUSY) |->
    busy_cnt >= WRITE_CYCLES - 1 && busy_cnt <= WRITE_CYCLES + 1) else $error("busy len");
  a_drive_clock_low: assert property ($changed(SDA_OE) |-> !LINK_SCL)
    else $error("data moved with clock high");
  a_tx_msb_first: assert property (TX_LOAD |-> SDA_OE == !$past(TX_DATA[7]))
    else $error("first read bit wrong");
  a_rx_single: assert property (RX_VALID |=> !RX_VALID) else $error("rx pulse long");
  a_addr_single: assert property (ADDR_VALID |=> !ADDR_VALID) else $error("addr pulse");
  c_program: cover property (START_PROGRAM);
  c_tx_load: cover property (TX_LOAD);
  c_addr: cover property (ADDR_VALID);
endmodule
bind eeprom_bus_slave eeprom_bus_slave_sva #(.WRITE_CYCLES(WRITE_CYCLES)) chk_u (
  .CORE_CLK(CORE_CLK), .NRST(NRST), .LINK_SCL(LINK_SCL), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
  .TX_DATA(TX_DATA), .TX_LOAD(TX_LOAD), .ADDR_VALID(ADDR_VALID), .RX_VALID(RX_VALID),
  .WRITE_BUSY(WRITE_BUSY), .START_PROGRAM(START_PROGRAM));

// >>> tb/bus_master_model.sv
// Purpose: bus master model making clock and data
// Assumes: pull-up on the data line; clock driven high and low
// Notes: clock stands high outside frames
`timescale 1ns/1ns
module bus_master_model (
  output logic scl,
  output logic sda_oe,
  input wire logic sda
);
  // ----
  // bit and byte tasks
  // ----
  localparam int Q = 160;
  int gl = 0;
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  task automatic start_bus();
    sda_oe = 1'b0;
    #Q scl = 1'b1;
    #Q sda_oe = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic stop_bus();
    sda_oe = 1'b1;
    #Q scl = 1'b1;
    #Q sda_oe = 1'b0;
    #(4 * Q);
  endtask
  // data set mid low phase, optional high glitch a quarter into high phase, ended before the sample
  task automatic put(input logic b, output logic got);
    sda_oe = !b;
    #Q scl = 1'b1;
    if (gl > 0 && !b) begin
      #(Q / 2) sda_oe = 1'b0;
      #gl sda_oe = 1'b1;
      #(Q / 2 - gl) got = sda;
    end else begin
      #Q got = sda;
    end
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic x;
    for (int i = 7; i >= 0; i--) put(d[i], x);
    put(1'b1, x);
    ack = !x;
  endtask
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic x;
    for (int i = 7; i >= 0; i--) put(1'b1, d[i]);
    put(nack, x);
  endtask
endmodule

// >>> tb/serial_eeprom_bus_slave_addressing_tb_top.sv
// Purpose: self-checking bench of eeprom_bus_slave
// Assumes: pull-up resolves the data line
// Notes: write cycle shortened to WCYC core cycles
`timescale 1ns/1ns
module serial_eeprom_bus_slave_addressing_tb_top;
  import eeprom_slave_pkg::*;
  // ----
  // harness
  // ----
  localparam logic [3:0] DEV_TYPE = 4'h5; // arbitrary value
  localparam int WCYC = 2000;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic mode_fast = 1'b0;
  logic [2:0] strap = 3'h5;
  logic [7:0] tx_data = 8'h96;
  logic [7:0] n_prog = 8'h00;
  logic [7:0] n_addr = 8'h00, n_rx = 8'h00, n_load = 8'h00;
  logic scl, m_oe, sda_out, sda_oe, tx_load, addr_valid, rx_valid, write_busy, start_program;
  logic [7:0] array_addr, rx_data;
  logic a;
  int n_mismatch = 0;
  int tests_run = 0;
  wire sda = !((sda_oe && !sda_out) || m_oe);
  eeprom_bus_slave #(.DEVICE_TYPE(DEV_TYPE), .WRITE_CYCLES(WCYC)) dut_u (
    .CORE_CLK(core_clk), .NRST(nrst), .LINK_SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe), .SELECT_STRAP_BIT0(strap[0]), .SELECT_STRAP_BIT1(strap[1]),
    .SELECT_STRAP_BIT2(strap[2]), .MODE_FAST(mode_fast), .TX_DATA(tx_data), .TX_LOAD(tx_load),
    .ARRAY_ADDR(array_addr), .ADDR_VALID(addr_valid), .RX_DATA(rx_data), .RX_VALID(rx_valid),
    .WRITE_BUSY(write_busy), .START_PROGRAM(start_program));
  bus_master_model m_u (.scl(scl), .sda_oe(m_oe), .sda(sda));
  initial begin
    forever #10 core_clk = !core_clk;
  end
  always @(posedge core_clk) begin
    if (start_program === 1'b1) n_prog <= n_prog + 8'h01;
    if (tx_load === 1'b1) tx_data <= ~tx_data;
    if (tx_load === 1'b1) n_load <= n_load + 8'h01;
    if (addr_valid === 1'b1) n_addr <= n_addr + 8'h01;
    if (rx_valid === 1'b1) n_rx <= n_rx + 8'h01;
  end
  task check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task complete_run();
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task t_write();
    logic a0, a1, a2;
    m_u.start_bus();
    m_u.wbyte({DEV_TYPE, strap, 1'b0}, a0);
    m_u.wbyte(8'h3c, a1);
    m_u.wbyte(8'ha5, a2);
    check(8'({a0, a1, a2}), 8'h07);
    check(array_addr, 8'h3c);
    check(rx_data, 8'ha5);
    check(n_addr, 8'h01);
    check(n_rx, 8'h01);
    m_u.stop_bus();
    check(n_prog, 8'h01);
    check(8'(write_busy), 8'h01);
    m_u.start_bus();
    m_u.wbyte({DEV_TYPE, strap, 1'b0}, a0);
    check(8'(a0), 8'h00);
    m_u.stop_bus();
    for (int i = 0; i < 2 * WCYC && write_busy !== 1'b0; i++) @(posedge core_clk) #1;
    check(8'(write_busy), 8'h00);
    if (write_busy !== 1'b0) complete_run();
    $display("write test done");
  endtask
  task t_select();
    for (int s = 0; s < 9; s++) begin
      @(posedge core_clk) #1 strap = s < 8 ? 3'(s) : 3'h5;
      m_u.start_bus();
      m_u.wbyte({s < 8 ? DEV_TYPE : ~DEV_TYPE, 3'h5, 1'b0}, a);
      check(8'(a), 8'(s == 5));
      m_u.wbyte(8'h11, a);
      check(8'(a), 8'(s == 5));
      m_u.stop_bus();
    end
    check(n_prog, 8'h01);
    check(n_addr, 8'h02);
    $display("select test done");
  endtask
  task t_read();
    logic [7:0] d0, d1;
    m_u.start_bus();
    m_u.wbyte({DEV_TYPE, strap, 1'b1}, a);
    m_u.rbyte(1'b0, d0);
    m_u.rbyte(1'b1, d1);
    m_u.stop_bus();
    check(8'(a), 8'h01);
    check(d0, 8'h96);
    check(d1, 8'h69);
    check(n_prog, 8'h01);
    check(n_load, 8'h02);
    $display("read test done");
  endtask
  task t_glitch();
    for (int m = 0; m < 2; m++) begin
      @(posedge core_clk) #1 mode_fast = 1'(m);
      m_u.start_bus();
      m_u.wbyte({DEV_TYPE, strap, 1'b0}, a);
      m_u.gl = m ? 30 : 60;
      m_u.wbyte(8'h42, a);
      m_u.gl = 0;
      check(8'(a), 8'h01);
      check(array_addr, 8'h42);
      m_u.stop_bus();
    end
    check(n_addr, 8'h04);
    $display("glitch test done");
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    #1 nrst = 1'b1;
    repeat (20) @(posedge core_clk);
    #1;
    t_write();
    t_select();
    t_read();
    t_glitch();
    complete_run();
  end
endmodule
